//--- design/sss_pkg.sv
// constants, types and register map of the safe stop supervisor
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package sss_pkg;

  // ----------------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------------
  localparam int CLK_HZ          = 200_000_000;
  localparam int TICK_US         = 1;                             // timer unit
  localparam int TICK_CYC        = CLK_HZ / 1_000_000 * TICK_US;  // 200 cycles
  localparam int REFRESH_RESP_US = 8000;                          // 8.0 ms
  localparam int WATCH_MULT      = 2;

  // ----------------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------------
  localparam int SPD_W = 16;
  localparam int POS_W = 32;

  // ----------------------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] REG_CFG_BASE = 8'h10;
  localparam logic [7:0] REG_RESP_TIM = 8'h34;

  // config word indices, offset = REG_CFG_BASE + 4 * index
  localparam int CFG_SS1_TIME  = 0;  // ss1_monitor_time, us
  localparam int CFG_STOP_SPD  = 1;  // stop_speed_limit
  localparam int CFG_DET_DLY   = 2;  // speed_detect_delay, us
  localparam int CFG_FB_TIME   = 3;  // fb_fixed_detect_time, us
  localparam int CFG_DEC_TC    = 4;  // decel_monitor_time_constant, us
  localparam int CFG_DEC_OFS   = 5;  // decel_monitor_speed_offset
  localparam int CFG_DEC_DLY   = 6;  // decel_monitor_delay, us
  localparam int CFG_TX_WATCH  = 7;  // tx_interval_watch_time, us
  localparam int CFG_PEER_CODE = 8;  // peer_check_code
  localparam int CFG_N         = 9;

  localparam logic [31:0] CFG_RST [CFG_N] = '{
    32'h0000_2710, 32'h0000_0032, 32'h0000_03e8, 32'h0000_2710, 32'h0000_2710,
    32'h0000_0064, 32'h0000_0000, 32'h0000_7530, 32'h0000_0000};

  // control fields
  localparam int CTRL_SAFETY_EN = 0;  // frozen feedback diagnosis enable
  localparam int CTRL_DECEL_MON = 1;  // 1: deceleration monitoring, 0: time only
  localparam int CTRL_NET_EN    = 2;  // network watch and code check
  localparam int CTRL_W         = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h1;

  // interrupt / alarm status bits
  localparam int IRQ_FB_ALM   = 0;
  localparam int IRQ_CODE_ALM = 1;
  localparam int IRQ_WD_ALM   = 2;
  localparam int IRQ_STO_IN   = 3;
  localparam int IRQ_SS1_IN   = 4;
  localparam int IRQ_CFG_ERR  = 5;
  localparam int IRQ_W        = 6;
  localparam logic [IRQ_W-1:0] IRQ_FAULTS = 6'h07;  // alarms that force torque off

  // status fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_MON_ACT   = 2;
  localparam int STAT_TRIP_SEEN = 3;
  localparam int STAT_OBS_LSB   = 16;

  typedef enum logic [1:0] {ST_RUN, ST_SS1, ST_STO} sss_state_e;

  typedef struct packed {
    logic signed [SPD_W-1:0] spd_cmd;
    logic signed [SPD_W-1:0] spd_fb;
    logic [POS_W-1:0]        pos;
  } sss_motion_s;

endpackage

//--- design/sss_top.sv
// safe stop supervisor: torque off and stop one sequencing, feedback and link checks
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
module sss_top import sss_pkg::*; (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // safety commands and alarm classes
  input  wire logic        torque_off_request_n_in,
  input  wire logic        stop1_request_n_in,
  input  wire logic        sto_alarm_in,
  input  wire logic        ss1_alarm_in,
  // safety network
  input  wire logic        refresh_req_in,
  input  wire logic [31:0] master_code_in,
  output logic             refresh_ack_out,
  // drive speed and position path
  input  wire sss_motion_s motion_in,
  // drive control and interrupt
  output logic             energy_cut_out,
  output logic             dyn_brake_out,
  output logic             decel_req_out,
  output logic             irq_out
);

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  sss_state_e        state_ff, nxt_state;
  logic              ack_ff;
  logic [31:0]       rd_data;
  logic              wr_en;
  logic [CTRL_W-1:0] ctrl_ff;
  logic [31:0]       cfg_ff [CFG_N];
  logic [IRQ_W-1:0]  irq_stat_ff, irq_mask_ff, irq_ev;
  logic [7:0]        tick_cnt_ff;
  logic              tick;
  logic [31:0]       ss1_tmr_ff, det_cnt_ff, fb_cnt_ff, wd_cnt_ff;
  logic              trip_seen_ff;
  logic [POS_W-1:0]  last_pos_ff;
  logic [SPD_W:0]    obs_ff, obs_start_ff, abs_cmd, abs_fb;
  logic [33:0]       oacc_ff;
  logic              refresh_ack_ff;
  logic              sto_cause, ss1_cause, ss1_exp, mon_active, mon_stop;
  logic              fb_en, fb_trip, wd_trip, code_mis, cfg_err;
  logic [3:0]        cfg_idx;
  logic              cfg_hit;

  function automatic logic [SPD_W:0] abs_spd(input logic signed [SPD_W-1:0] v);
    logic signed [SPD_W:0] w;
    w = {v[SPD_W-1], v};
    abs_spd = w[SPD_W] ? 17'(-w) : 17'(w);
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    be_merge = r;
  endfunction

  // ----------------------------------------------------------------------------
  // avalon-mm slave
  // ----------------------------------------------------------------------------
  // one wait state: answer on the second cycle of every request
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_ff;
  assign wr_en = avs_write_in & ack_ff;
  assign cfg_idx = 4'((avs_address_in - REG_CFG_BASE) >> 2);
  assign cfg_hit = (avs_address_in >= REG_CFG_BASE) && (avs_address_in[1:0] == 2'h0)
                   && (cfg_idx < 4'(CFG_N));

  // ack drops the cycle after it rises, so a held request is never taken in two cycles running
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read_in | avs_write_in) & ~ack_ff;
    end
  end

  // read mux; unmapped addresses read zero, except 0x50-0x70, 0x90-0xb0 and 0xd0-0xf0, which alias the config words
  always_comb begin
    rd_data = 32'h0;
    if (cfg_hit) begin
      rd_data = cfg_ff[cfg_idx];
    end else begin
      unique case (avs_address_in)
        REG_CTRL:     rd_data = 32'(ctrl_ff);
        REG_STATUS:   rd_data = {obs_ff[15:0], 12'h0, trip_seen_ff, mon_active, state_ff};
        REG_IRQ_STAT: rd_data = 32'(irq_stat_ff);
        REG_IRQ_MASK: rd_data = 32'(irq_mask_ff);
        REG_RESP_TIM: rd_data = 32'(REFRESH_RESP_US);
        default:      rd_data = 32'h0;
      endcase
    end
  end

  // read data captured as the answer is prepared, held until the next one
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      avs_readdata_out <= 32'h0;
    end else if (avs_read_in & ~ack_ff) begin
      avs_readdata_out <= rd_data;
    end
  end

  // writable control and configuration; writes to unmapped offsets dropped, except config aliases at 0x50-0x70, 0x90-0xb0 and 0xd0-0xf0
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ctrl_ff     <= CTRL_RST;
      irq_mask_ff <= '0;
      for (int i = 0; i < CFG_N; i++) begin
        cfg_ff[i] <= CFG_RST[i];
      end
    end else if (wr_en) begin
      if (cfg_hit) begin
        cfg_ff[cfg_idx] <= be_merge(cfg_ff[cfg_idx], avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in == REG_CTRL && avs_byteenable_in[0]) begin
        ctrl_ff <= avs_writedata_in[CTRL_W-1:0];
      end else if (avs_address_in == REG_IRQ_MASK && avs_byteenable_in[0]) begin
        irq_mask_ff <= avs_writedata_in[IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------------------
  assign irq_ev = {cfg_err, (state_ff == ST_RUN) && (nxt_state == ST_SS1),
                   (state_ff != ST_STO) && (nxt_state == ST_STO), wd_trip, code_mis, fb_trip};

  // write-one-to-clear; a new event in the same cycle wins over the clear
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      irq_stat_ff <= '0;
    end else if (wr_en && avs_address_in == REG_IRQ_STAT && avs_byteenable_in[0]) begin
      irq_stat_ff <= (irq_stat_ff & ~avs_writedata_in[IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat_ff <= irq_stat_ff | irq_ev;
    end
  end

  // level output; stays high until software clears or masks every pending bit
  assign irq_out = |(irq_stat_ff & irq_mask_ff);

  // ----------------------------------------------------------------------------
  // microsecond tick
  // ----------------------------------------------------------------------------
  // free-running divider: a timer counted in whole ticks may end up to one tick early
  assign tick = (tick_cnt_ff == 8'(TICK_CYC - 1));

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || tick) begin
      tick_cnt_ff <= 8'h0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 8'h1;
    end
  end

  // ----------------------------------------------------------------------------
  // stop sequencer
  // ----------------------------------------------------------------------------
  // latched faults keep torque off until software clears them
  assign sto_cause = ~torque_off_request_n_in | sto_alarm_in | (|(irq_stat_ff & IRQ_FAULTS));
  assign ss1_cause = ~stop1_request_n_in | ss1_alarm_in;
  assign ss1_exp   = ss1_tmr_ff >= cfg_ff[CFG_SS1_TIME];

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RUN: begin
        if (sto_cause) begin
          nxt_state = ST_STO;
        end else if (ss1_cause) begin
          nxt_state = ST_SS1;
        end
      end
      ST_SS1: begin
        if (sto_cause || ss1_exp || mon_stop) begin
          nxt_state = ST_STO;
        end else if (!ss1_cause) begin
          nxt_state = ST_RUN;
        end
      end
      ST_STO: begin
        if (!sto_cause && !ss1_cause) begin
          nxt_state = ST_RUN;
        end
      end
    endcase
  end

  // reset parks the drive in torque off; it leaves only once every cause has cleared
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state_ff <= ST_STO;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // energy cut and brake only in torque off; torque off never sets an alarm
  assign energy_cut_out = (state_ff == ST_STO);
  assign dyn_brake_out  = (state_ff == ST_STO);
  assign decel_req_out  = (state_ff == ST_SS1);

  // stop one elapsed time in ticks, saturating
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || state_ff != ST_SS1) begin
      ss1_tmr_ff <= 32'h0;
    end else if (tick && ss1_tmr_ff != 32'hffff_ffff) begin
      ss1_tmr_ff <= ss1_tmr_ff + 32'h1;
    end
  end

  // ----------------------------------------------------------------------------
  // deceleration monitoring
  // ----------------------------------------------------------------------------
  assign abs_cmd    = abs_spd(motion_in.spd_cmd);
  assign abs_fb     = abs_spd(motion_in.spd_fb);
  assign mon_active = (state_ff == ST_SS1) && ctrl_ff[CTRL_DECEL_MON]
                      && (ss1_tmr_ff >= cfg_ff[CFG_DEC_DLY]);
  assign mon_stop   = trip_seen_ff && (det_cnt_ff >= cfg_ff[CFG_DET_DLY]);

  // once stop or overspeed is seen, the detect delay runs to torque off
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || state_ff != ST_SS1) begin
      trip_seen_ff <= 1'b0;
    end else if (mon_active && ((abs_cmd <= 17'(cfg_ff[CFG_STOP_SPD][15:0])
                 && abs_fb <= 17'(cfg_ff[CFG_STOP_SPD][15:0])) || abs_fb > obs_ff)) begin
      trip_seen_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || !trip_seen_ff) begin
      det_cnt_ff <= 32'h0;
    end else if (tick && det_cnt_ff != 32'hffff_ffff) begin
      det_cnt_ff <= det_cnt_ff + 32'h1;
    end
  end

  // observation speed: linear fall from start to zero over the time constant;
  // decrements at most one unit a cycle and never on a tick, so start/constant must stay at or below 199 per us
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      obs_ff       <= '0;
      obs_start_ff <= '0;
      oacc_ff      <= '0;
    end else if (state_ff != ST_SS1) begin
      obs_ff       <= 17'(abs_fb + 17'(cfg_ff[CFG_DEC_OFS][15:0]));
      obs_start_ff <= 17'(abs_fb + 17'(cfg_ff[CFG_DEC_OFS][15:0]));
      oacc_ff      <= '0;
    end else if (cfg_ff[CFG_DEC_TC] == 32'h0) begin
      obs_ff <= '0;
    end else if (tick) begin
      oacc_ff <= oacc_ff + 34'(obs_start_ff);
    end else if (oacc_ff >= 34'(cfg_ff[CFG_DEC_TC]) && obs_ff != '0) begin
      oacc_ff <= oacc_ff - 34'(cfg_ff[CFG_DEC_TC]);
      obs_ff  <= obs_ff - 17'h1;
    end
  end

  // ----------------------------------------------------------------------------
  // frozen feedback diagnosis
  // ----------------------------------------------------------------------------
  assign fb_en   = ctrl_ff[CTRL_SAFETY_EN] && (state_ff != ST_STO);
  assign fb_trip = fb_en && (fb_cnt_ff >= cfg_ff[CFG_FB_TIME]);

  // last position tracked even while disabled, so re-enabling starts from a clean count
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      last_pos_ff <= '0;
      fb_cnt_ff   <= 32'h0;
    end else begin
      last_pos_ff <= motion_in.pos;
      if (!fb_en || motion_in.pos != last_pos_ff) begin
        fb_cnt_ff <= 32'h0;
      end else if (tick && !fb_trip) begin
        fb_cnt_ff <= fb_cnt_ff + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // safety network: refresh answer, watch time, code check
  // ----------------------------------------------------------------------------
  // answered the next cycle, far inside the fixed refresh response time
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      refresh_ack_ff <= 1'b0;
    end else begin
      refresh_ack_ff <= refresh_req_in;
    end
  end

  assign refresh_ack_out = refresh_ack_ff;
  assign code_mis = ctrl_ff[CTRL_NET_EN] && refresh_req_in
                    && (master_code_in != cfg_ff[CFG_PEER_CODE]);
  assign wd_trip  = ctrl_ff[CTRL_NET_EN] && (wd_cnt_ff >= cfg_ff[CFG_TX_WATCH]);
  // flags a watch time below twice the refresh response time
  assign cfg_err  = ctrl_ff[CTRL_NET_EN]
                    && (cfg_ff[CFG_TX_WATCH] < 32'(WATCH_MULT * REFRESH_RESP_US));

  // watch counter restarts on every refresh and stops once tripped
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || refresh_req_in || !ctrl_ff[CTRL_NET_EN]) begin
      wd_cnt_ff <= 32'h0;
    end else if (tick && !wd_trip) begin
      wd_cnt_ff <= wd_cnt_ff + 32'h1;
    end
  end

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  // stop one entry, and a stop one still running undisturbed
  sequence s_ss1_enter;
    state_ff == ST_RUN && !sto_cause && ss1_cause;
  endsequence

  sequence s_ss1_running;
    state_ff == ST_SS1 && !sto_cause && !ss1_exp && !mon_stop && ss1_cause;
  endsequence

  AST_TOQ_STO: assert property (!torque_off_request_n_in |=> energy_cut_out && dyn_brake_out)
    else $error("torque off request did not cut energy");
  AST_TOQ_RELEASE: assert property (state_ff == ST_STO && !sto_cause && !ss1_cause
    |=> state_ff == ST_RUN && !energy_cut_out) else $error("torque off not released");
  AST_ALARM_STO: assert property (sto_alarm_in |=> state_ff == ST_STO)
    else $error("torque off alarm ignored");
  AST_NO_ALARM: assert property ($fell(torque_off_request_n_in) && !code_mis && !wd_trip
    && !fb_trip |=> $stable(irq_stat_ff[IRQ_WD_ALM:IRQ_FB_ALM])) else $error("alarm on torque off");
  AST_SS1_SEQ: assert property (s_ss1_enter ##1 s_ss1_running |-> decel_req_out && !energy_cut_out)
    else $error("stop one not decelerating");
  AST_SS1_TIMEOUT: assert property (state_ff == ST_SS1 && ss1_exp |=> state_ff == ST_STO)
    else $error("stop one timer expiry missed");
  AST_SS1_HOLD: assert property (state_ff == ST_STO && !stop1_request_n_in |=> state_ff == ST_STO)
    else $error("torque off left during stop one request");
  AST_FB_IDLE: assert property (state_ff == ST_STO ##1 state_ff == ST_STO |-> fb_cnt_ff == 32'h0)
    else $error("feedback diagnosis ran in torque off");
  AST_FB_ALARM: assert property (fb_trip |=> irq_stat_ff[IRQ_FB_ALM] ##1 state_ff == ST_STO)
    else $error("frozen feedback not handled");
  AST_CODE_MIS: assert property (code_mis |=> irq_stat_ff[IRQ_CODE_ALM])
    else $error("code mismatch not flagged");
  AST_REFRESH: assert property (refresh_req_in |=> refresh_ack_out)
    else $error("refresh not answered");
  AST_MON_DELAY: assert property (trip_seen_ff |-> $past(ss1_tmr_ff) >= cfg_ff[CFG_DEC_DLY])
    else $error("speed monitored before delay");

  // sequence entry, release, priority, monitor outcome and watch time check
  AST_SS1_START: assert property (s_ss1_enter |=> state_ff == ST_SS1 && ss1_tmr_ff == 32'h0)
    else $error("stop one timer not started from zero");
  AST_SS1_RETURN: assert property (state_ff == ST_SS1 && !sto_cause && !ss1_exp && !mon_stop
    && !ss1_cause |=> state_ff == ST_RUN) else $error("stop one not released");
  AST_STO_PRIO: assert property (state_ff == ST_SS1 && sto_cause |=> state_ff == ST_STO)
    else $error("torque off lost to stop one");
  AST_MON_STOP: assert property (state_ff == ST_SS1 && mon_stop |=> state_ff == ST_STO)
    else $error("monitored stop did not cut torque");
  AST_CFG_ERR: assert property (cfg_err |=> irq_stat_ff[IRQ_CFG_ERR])
    else $error("short watch time not flagged");

endmodule

//--- sim/sss_master_model.sv
// safety master station and motion feed model for the safe stop supervisor
`timescale 1ns/1ps
module sss_master_model import sss_pkg::*; (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  // bench control
  input  wire logic        send_in,
  input  wire logic [31:0] code_in,
  input  wire logic        freeze_in,
  // device side
  input  wire logic        refresh_ack_in,
  output logic             refresh_req_out,
  output logic      [31:0] master_code_out,
  output sss_motion_s      motion_out,
  output logic             ack_miss_out
);
  logic pend_ff;
  // ----------------------------------------------------------------------
  // refresh issue and answer watch
  // ----------------------------------------------------------------------
  // code is only valid with the request; otherwise show the inverse
  always_ff @(posedge clk_sys_in) begin
    refresh_req_out <= send_in;
    pend_ff         <= refresh_req_out;
    if (sys_rst_in) begin
      master_code_out <= 32'h0;
      ack_miss_out    <= 1'b0;
    end else begin
      master_code_out <= send_in ? code_in : ~master_code_out;
      if (pend_ff && !refresh_ack_in) begin
        ack_miss_out <= 1'b1;
      end
    end
  end
  // speeds held at zero, position steps every cycle unless frozen; the stop monitor always sees standstill
  always_ff @(posedge clk_sys_in) begin
    motion_out.spd_cmd <= '0;
    motion_out.spd_fb  <= '0;
    if (sys_rst_in) begin
      motion_out.pos <= '0;
    end else if (!freeze_in) begin
      motion_out.pos <= motion_out.pos + 32'h0000_0001;
    end
  end
endmodule

//--- sim/testbench.sv
// self-checking bench for the safe stop supervisor
`timescale 1ns/1ps
module testbench;
  import sss_pkg::*;
  logic clk_sys_in, sys_rst_in, rd_in, wr_in, wait_out, ack_out, req_out, miss_out;
  logic [7:0] addr_in;
  logic [31:0] wdata_in, rdata_out, code_out, code_in, rv;
  logic sto_n, ss1_n, sto_alm, ss1_alm, send, freeze, cut, brake, decel, irq;
  sss_motion_s motion;
  int n_mismatch, tests_run, cycles;
  sss_top dut_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .avs_address_in(addr_in),
    .avs_read_in(rd_in), .avs_write_in(wr_in), .avs_writedata_in(wdata_in),
    .avs_byteenable_in(4'hf), .avs_readdata_out(rdata_out), .avs_waitrequest_out(wait_out),
    .torque_off_request_n_in(sto_n), .stop1_request_n_in(ss1_n), .sto_alarm_in(sto_alm),
    .ss1_alarm_in(ss1_alm), .refresh_req_in(req_out), .master_code_in(code_out),
    .refresh_ack_out(ack_out), .motion_in(motion), .energy_cut_out(cut),
    .dyn_brake_out(brake), .decel_req_out(decel), .irq_out(irq));
  sss_master_model master_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .send_in(send),
    .code_in(code_in), .freeze_in(freeze), .refresh_ack_in(ack_out), .refresh_req_out(req_out),
    .master_code_out(code_out), .motion_out(motion), .ack_miss_out(miss_out));
  // ----------------------------------------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  // a hang anywhere ends the run as a failure
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic close_out();
    if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // one bus cycle; samples taken before the edge's own updates land
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= w;
    rd_in    <= !w;
    do @(posedge clk_sys_in); while (wait_out !== 1'b0);
    rv = rdata_out;
    wr_in <= 1'b0;
    rd_in <= 1'b0;
  endtask
  task automatic refresh(input logic [31:0] c);
    @(posedge clk_sys_in);
    send    <= 1'b1;
    code_in <= c;
    @(posedge clk_sys_in);
    send <= 1'b0;
    cyc(4);
  endtask
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {rd_in, wr_in, send, freeze, sto_alm, ss1_alm} = '0;
    {addr_in, wdata_in, code_in} = '0;
    {sto_n, ss1_n} = 2'b11;
    sys_rst_in = 1'b1;
    cyc(6);
    sys_rst_in <= 1'b0;
    cyc(4);
    chk(cut, 1'b0);
    bus(0, REG_RESP_TIM, 0); chk(rv, 32'd8000);
    bus(0, 8'h3c, 0); chk(rv, 32'h0);
    // short timers; watch time at its lowest legal value
    bus(1, 8'h10, 32'd3);
    bus(1, 8'h18, 32'd1);
    bus(1, 8'h1c, 32'd4);
    bus(1, 8'h2c, 32'd16000);
    bus(1, 8'h30, 32'd5);
    bus(1, REG_IRQ_STAT, 32'h3f);
    bus(1, REG_IRQ_MASK, 32'h3f);
    bus(0, REG_IRQ_STAT, 0); chk(rv, 32'h0);
    // torque off by request, then by alarm
    sto_n <= 1'b0;
    cyc(3); chk({cut, brake, irq}, 3'b111);
    bus(0, REG_IRQ_STAT, 0); chk(rv, 32'h8);
    sto_n <= 1'b1;
    cyc(3); chk(cut, 1'b0);
    bus(1, REG_IRQ_STAT, 32'h3f); cyc(1); chk(irq, 1'b0);
    sto_alm <= 1'b1;
    cyc(3); chk({cut, brake}, 2'b11);
    sto_alm <= 1'b0;
    // timed stop one; torque off only once the monitor time is over
    bus(1, REG_IRQ_STAT, 32'h3f);
    ss1_n <= 1'b0;
    cyc(3); chk({decel, cut}, 2'b10);
    cyc(400); chk(cut, 1'b0);
    cyc(400); chk(cut, 1'b1);
    cyc(10); chk(cut, 1'b1);
    ss1_n <= 1'b1;
    cyc(3); chk({decel, cut}, 2'b00);
    ss1_alm <= 1'b1;
    cyc(3); chk(decel, 1'b1);
    ss1_alm <= 1'b0;
    cyc(900);
    // monitored stop: standstill reached, torque off after detect delay
    bus(1, REG_CTRL, 32'h3);
    bus(1, REG_IRQ_STAT, 32'h3f);
    cyc(3); chk(cut, 1'b0);
    ss1_n <= 1'b0;
    cyc(400); chk(cut, 1'b1);
    ss1_n <= 1'b1;
    // frozen feedback, with diagnosis on and then off
    bus(1, REG_CTRL, 32'h1);
    bus(1, REG_IRQ_STAT, 32'h3f);
    freeze <= 1'b1;
    cyc(1000); chk(cut, 1'b1);
    bus(0, REG_IRQ_STAT, 0); chk(rv[0], 1'b1);
    bus(1, REG_CTRL, 32'h0);
    freeze <= 1'b0;
    bus(1, REG_IRQ_STAT, 32'h3f);
    freeze <= 1'b1;
    cyc(1000);
    bus(0, REG_IRQ_STAT, 0); chk(rv[0], 1'b0);
    freeze <= 1'b0;
    // code check over the safety link
    bus(1, REG_CTRL, 32'h5);
    bus(1, REG_IRQ_STAT, 32'h3f);
    refresh(32'd5);
    bus(0, REG_IRQ_STAT, 0); chk(rv[2:0], 3'h0);
    refresh(32'd6);
    bus(0, REG_IRQ_STAT, 0); chk(rv[2:0], 3'h2);
    // watch time below twice the refresh time, then the watch runs out
    bus(1, REG_IRQ_STAT, 32'h3f);
    bus(1, 8'h2c, 32'd2);
    cyc(1000);
    bus(0, REG_IRQ_STAT, 0); chk(rv, 32'h2c);
    chk(cut, 1'b1);
    chk(miss_out, 1'b0);
    close_out();
  end
endmodule
